// File: rtl/buck_seq_defines.vh
`ifndef BUCK_SEQ_DEFINES_VH
`define BUCK_SEQ_DEFINES_VH

// register byte offsets
`define REG_OSC_PERIOD 8'h00
`define REG_LOSS_LIMIT 8'h04
`define REG_STATUS 8'h08

// reset values and period minimum
`define OSC_PERIOD_RST 16'h00FA
`define OSC_PERIOD_MIN 16'h0004
`define LOSS_LIMIT_RST 8'h04

// status field positions
`define ST_STATE_LSB 0
`define ST_EXT_LOCK 2
`define ST_LOCKOUT 3
`define ST_THERMAL 4
`define ST_RESET_REL 5
`define ST_SYNC_LVL 6
`define ST_CODE_LSB 8

// sequencer states
`define SEQ_OFF 2'h0
`define SEQ_UP 2'h1
`define SEQ_ON 2'h2
`define SEQ_DOWN 2'h3

// ramp timing in switching cycles
`define RAMP_CYCLES 1024
`define RAMP_STEPS 64
`define CYC_PER_STEP (`RAMP_CYCLES / `RAMP_STEPS)
`define CODE_TOP 6'h3F

// time constants
`define CLK_PERIOD_NS 20
`define DEAD_NS 30
`define DEAD_CYC ((`DEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/dual_buck_sequencer.v
// Contract
// - lockout holds all gate outputs low
// - lockout drives reset output low
// - lockout release starts power-up of both outputs
// - enable high runs, low shuts both down
// - shutdown: gates low, compensation nodes discharged
// - enable rise starts common ramp from zero, or from the present code during ramp-down
// - ramp lasts 1024 switching cycles, 64 steps
// - regulation reached when final ramp step ends
// - enable fall starts common reverse ramp
// - shutdown entered only after ramp-down completes
// - reset low while any output under 90%
// - reset released: both good, ramps done
// - reset output is open drain, low only
// - timing low: output equals first regulator clock
// - timing high: double rate, 90 degree shift
// - external timing input divided by two
// - first regulator cycle starts on clock rise
// - external mode: output in phase with regulator
// - only rising timing edges synchronise
// - lost timing edges fall back to internal oscillator
// - switching rate is half the oscillator rate
// - overtemperature stops all, resets ramp, restarts later
// - channels start half a switching period apart
// - current limit skips high side that cycle
// - low side complements high side after dead time
`timescale 1ns/10ps
`include "buck_seq_defines.vh"

module dual_buck_sequencer #(
	parameter [15:0] OSC_PERIOD = `OSC_PERIOD_RST,
	parameter [7:0] LOSS_LIMIT = `LOSS_LIMIT_RST
) (
	// clock and reset
	input wire CLK,
	input wire RST_N,
	// apb slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	// control and comparator inputs
	input wire EN,
	input wire LOW_SUPPLY_LOCKOUT,
	input wire THERMAL_HOT,
	input wire SYNC,
	input wire [1:0] ILIM,
	input wire [1:0] PWM_OFF,
	input wire [1:0] OUT_GOOD,
	// gate drive and analog controls
	output wire [1:0] HIGH_SIDE_GATE,
	output wire [1:0] LOW_SIDE_GATE,
	output reg [1:0] COMP_DISCHARGE,
	output reg [5:0] REF_CODE,
	// timing output and open-drain reset
	output reg TIMING_OUTPUT,
	output reg RESET_OUT_O,
	output reg RESET_OUT_OE
);

	// ramp and dead-time counts cut to their counter widths
	localparam [31:0] STEP_LAST_W = `CYC_PER_STEP - 1;
	localparam [31:0] DEAD_CYC_W = `DEAD_CYC;
	localparam [3:0] STEP_LAST = STEP_LAST_W[3:0];
	localparam [2:0] DEAD_CYC = DEAD_CYC_W[2:0];

	// writable settings
	reg [15:0] osc_period_q;
	reg [7:0] loss_limit_q;
	// oscillator, timing input and switching clock
	reg [15:0] osc_cnt_q;
	reg sync_q;
	reg ext_lock_q;
	reg [7:0] miss_cnt_q;
	reg sw_q;
	// ramp sequencer
	reg [1:0] state_q;
	reg [5:0] code_q;
	reg [3:0] pre_q;
	// bus read path
	reg [31:0] rd_mux;
	reg addr_ok;

	// decoded conditions and strobes
	wire fault;
	wire active;
	wire int_tick;
	wire int_mid;
	wire sync_rise;
	wire osc_tick;
	wire [1:0] cyc_start;
	wire released;
	wire acc_wr;

	// faults force everything off
	assign fault = LOW_SUPPLY_LOCKOUT | THERMAL_HOT;
	assign active = (state_q != `SEQ_OFF) & ~fault;

	// internal oscillator: one tick per period, one mid-period pulse
	// >= so a period shortened mid-count wraps at once, not at overflow
	assign int_tick = (osc_cnt_q >= osc_period_q - 16'h0001);
	assign int_mid = (osc_cnt_q == {1'b0, osc_period_q[15:1]} - 16'h0001);

	always @(posedge CLK) begin
		if (!RST_N || int_tick)
			osc_cnt_q <= 16'h0000;
		else
			osc_cnt_q <= osc_cnt_q + 16'h0001;
	end

	// timing input edge detect, rising edges only
	assign sync_rise = SYNC & ~sync_q;

	always @(posedge CLK) begin
		if (!RST_N)
			sync_q <= 1'b0;
		else
			sync_q <= SYNC;
	end

	// external lock: edge locks, too many quiet periods drop it
	// a level held high gives one rise only, so it locks briefly
	// and then drops back to the internal oscillator
	always @(posedge CLK) begin
		if (!RST_N) begin
			ext_lock_q <= 1'b0;
			miss_cnt_q <= 8'h00;
		end else if (sync_rise) begin
			ext_lock_q <= 1'b1;
			miss_cnt_q <= 8'h00;
		end else if (int_tick) begin
			if (miss_cnt_q >= loss_limit_q)
				ext_lock_q <= 1'b0;
			else
				miss_cnt_q <= miss_cnt_q + 8'h01;
		end
	end

	// selected oscillator source; after lost edges no ticks until the lock drops to internal
	assign osc_tick = ext_lock_q ? sync_rise : int_tick;

	// switching clock is oscillator halved
	// one switching period spans two oscillator ticks
	always @(posedge CLK) begin
		if (!RST_N)
			sw_q <= 1'b0;
		else if (osc_tick)
			sw_q <= ~sw_q;
	end

	// channel 0 on switching clock rise, channel 1 on its fall
	assign cyc_start[0] = osc_tick & ~sw_q;
	assign cyc_start[1] = osc_tick & sw_q;

	// timing output per mode
	// unlocked with input low, or locked: follow the switching clock
	// input held high: twice the rate, a quarter period late
	always @(posedge CLK) begin
		if (!RST_N)
			TIMING_OUTPUT <= 1'b0;
		else if (ext_lock_q || !sync_q) begin
			if (osc_tick)
				TIMING_OUTPUT <= ~sw_q;
		end else if (int_mid)
			TIMING_OUTPUT <= 1'b1;
		else if (int_tick)
			TIMING_OUTPUT <= 1'b0;
	end

	// soft-start and soft-stop sequencer
	always @(posedge CLK) begin
		if (!RST_N || fault) begin
			state_q <= `SEQ_OFF;
			code_q <= 6'h00;
			pre_q <= 4'h0;
		end else begin
			case (state_q)
			// direction changes only at a channel 0 cycle start, so each
			// code is held for whole switching cycles: 64 codes of 16
			// cycles give the full 1024-cycle ramp
			`SEQ_OFF: begin
				if (EN && cyc_start[0]) begin
					state_q <= `SEQ_UP;
					code_q <= 6'h00;
					pre_q <= 4'h0;
				end
			end
			`SEQ_UP: begin
				if (cyc_start[0]) begin
					if (!EN) begin
						state_q <= `SEQ_DOWN;
						pre_q <= 4'h0;
					end else begin
						pre_q <= pre_q + 4'h1;
						if (pre_q == STEP_LAST) begin
							if (code_q == `CODE_TOP)
								state_q <= `SEQ_ON;
							else
								code_q <= code_q + 6'h01;
						end
					end
				end
			end
			`SEQ_ON: begin
				if (!EN && cyc_start[0]) begin
					state_q <= `SEQ_DOWN;
					pre_q <= 4'h0;
				end
			end
			`SEQ_DOWN: begin
				if (cyc_start[0]) begin
					if (EN) begin
						state_q <= `SEQ_UP;
						pre_q <= 4'h0;
					end else begin
						pre_q <= pre_q + 4'h1;
						if (pre_q == STEP_LAST) begin
							if (code_q == 6'h00)
								state_q <= `SEQ_OFF;
							else
								code_q <= code_q - 6'h01;
						end
					end
				end
			end
			default: begin
				state_q <= `SEQ_OFF;
			end
			endcase
		end
	end

	// reference code and compensation discharge
	// compensation nodes discharge whenever switching is stopped
	always @(posedge CLK) begin
		if (!RST_N) begin
			REF_CODE <= 6'h00;
			COMP_DISCHARGE <= 2'b11;
		end else begin
			REF_CODE <= fault ? 6'h00 : code_q;
			COMP_DISCHARGE <= {2{~active}};
		end
	end

	// open-drain reset: enable high pulls the pin low
	// released only in the on state with both outputs good
	assign released = (state_q == `SEQ_ON) & (&OUT_GOOD) & ~fault;

	always @(posedge CLK) begin
		if (!RST_N) begin
			RESET_OUT_O <= 1'b0;
			RESET_OUT_OE <= 1'b1;
		end else begin
			RESET_OUT_O <= 1'b0;
			RESET_OUT_OE <= ~released;
		end
	end

	// per-channel gate drive
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : chan
			reg hs_q;
			reg ls_q;
			reg pend_q;
			reg [2:0] dead_q;
			wire set_pend;
			wire stop;
			wire hs_d;
			wire ls_d;

			assign set_pend = cyc_start[i] & active & ~ILIM[i];
			assign stop = cyc_start[1 - i];
			assign hs_d = active & ((hs_q & ~PWM_OFF[i] & ~stop) |
				(pend_q & ~ls_q));
			assign ls_d = active & ~hs_q & ~hs_d & (dead_q == 3'h0) &
				~pend_q & ~set_pend;

			// high side waits for low side off; dead time after it
			// on-time ends on the off request or the other start
			// a start under current limit leaves the low side on
			always @(posedge CLK) begin
				if (!RST_N) begin
					hs_q <= 1'b0;
					ls_q <= 1'b0;
					pend_q <= 1'b0;
					dead_q <= 3'h0;
				end else begin
					hs_q <= hs_d;
					ls_q <= ls_d;
					if (!active || hs_d)
						pend_q <= 1'b0;
					else if (set_pend)
						pend_q <= 1'b1;
					if (hs_q)
						dead_q <= DEAD_CYC;
					else if (dead_q != 3'h0)
						dead_q <= dead_q - 3'h1;
				end
			end

			assign HIGH_SIDE_GATE[i] = hs_q;
			assign LOW_SIDE_GATE[i] = ls_q;
		end
	endgenerate

	// apb read mux and decode
	// status is read-only; writes to it are dropped without error
	// unmapped or misaligned addresses answer with an error
	always @* begin
		rd_mux = 32'h00000000;
		addr_ok = (PADDR[1:0] == 2'b00);
		case (PADDR)
		`REG_OSC_PERIOD: rd_mux[15:0] = osc_period_q;
		`REG_LOSS_LIMIT: rd_mux[7:0] = loss_limit_q;
		`REG_STATUS: begin
			rd_mux[`ST_STATE_LSB + 1:`ST_STATE_LSB] = state_q;
			rd_mux[`ST_EXT_LOCK] = ext_lock_q;
			rd_mux[`ST_LOCKOUT] = LOW_SUPPLY_LOCKOUT;
			rd_mux[`ST_THERMAL] = THERMAL_HOT;
			rd_mux[`ST_RESET_REL] = ~RESET_OUT_OE;
			rd_mux[`ST_SYNC_LVL] = sync_q;
			rd_mux[`ST_CODE_LSB + 5:`ST_CODE_LSB] = code_q;
		end
		default: addr_ok = 1'b0;
		endcase
	end

	// answer prepared in setup, completes in access phase
	// no wait states: ready always follows a setup cycle
	always @(posedge CLK) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			if (PSEL && !PENABLE) begin
				PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
				PSLVERR <= ~addr_ok;
			end else begin
				PSLVERR <= 1'b0;
			end
		end
	end

	assign acc_wr = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

	// writable registers
	// periods below the minimum are raised to it
	always @(posedge CLK) begin
		if (!RST_N) begin
			osc_period_q <= OSC_PERIOD;
			loss_limit_q <= LOSS_LIMIT;
		end else if (acc_wr) begin
			if (PADDR == `REG_OSC_PERIOD) begin
				if (PWDATA[15:0] < `OSC_PERIOD_MIN)
					osc_period_q <= `OSC_PERIOD_MIN;
				else
					osc_period_q <= PWDATA[15:0];
			end
			if (PADDR == `REG_LOSS_LIMIT)
				loss_limit_q <= PWDATA[7:0];
		end
	end

endmodule

// File: sim/buck_far.sv
`timescale 1ns/10ps
module buck_far (
	// pins seen from the board
	input wire CLK,
	input wire [1:0] HIGH_SIDE_GATE,
	input wire [5:0] REF_CODE,
	input wire RESET_OUT_O,
	input wire RESET_OUT_OE,
	// modelled feedback
	output logic [1:0] PWM_OFF = 2'h0,
	output logic [1:0] OUT_GOOD = 2'h0,
	output wire reset_pin
);
	// board pull-up lifts the released reset line
	assign reset_pin = RESET_OUT_OE ? RESET_OUT_O : 1'b1;
	// on-time ends a cycle later; outputs good at full reference
	always @(posedge CLK) begin
		PWM_OFF <= HIGH_SIDE_GATE;
		OUT_GOOD <= {2{REF_CODE == 6'h3F}};
	end
endmodule

// File: sim/buck_chk_sva.sv
`timescale 1ns/10ps
module buck_chk (
	// watched ports
	input wire CLK,
	input wire RST_N,
	input wire PSEL,
	input wire PENABLE,
	input wire PREADY,
	input wire LOW_SUPPLY_LOCKOUT,
	input wire THERMAL_HOT,
	input wire [1:0] OUT_GOOD,
	input wire [1:0] HIGH_SIDE_GATE,
	input wire [1:0] LOW_SIDE_GATE,
	input wire [5:0] REF_CODE,
	input wire RESET_OUT_O,
	input wire RESET_OUT_OE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// faults and supply lockout
	chk_fault_gates: assert property (
		LOW_SUPPLY_LOCKOUT || THERMAL_HOT |=> !(HIGH_SIDE_GATE | LOW_SIDE_GATE))
		else $error("gates active during fault");
	chk_lock_reset: assert property (
		LOW_SUPPLY_LOCKOUT |=> RESET_OUT_OE)
		else $error("reset released in lockout");
	chk_hot_ref: assert property (
		THERMAL_HOT [*2] |=> REF_CODE == 6'h00 && RESET_OUT_OE)
		else $error("ramp not reset when hot");
	// open-drain reset output
	chk_od_low: assert property (
		RESET_OUT_O == 1'b0)
		else $error("reset pin driven high");
	chk_low_output: assert property (
		!(&OUT_GOOD) |=> RESET_OUT_OE)
		else $error("reset released with low output");
	chk_release_done: assert property (
		$fell(RESET_OUT_OE) |-> REF_CODE == 6'h3F && $past(&OUT_GOOD))
		else $error("reset released before ramp end");
	// gate timing, ramp steps and apb ready
	chk_dead_time: assert property (
		$fell(HIGH_SIDE_GATE[0]) |-> !LOW_SIDE_GATE[0] [*2])
		else $error("low side on inside dead time");
	chk_ref_step: assert property (
		$changed(REF_CODE) && REF_CODE != 6'h00 |->
		REF_CODE == $past(REF_CODE) + 6'h01 ||
		REF_CODE == $past(REF_CODE) - 6'h01)
		else $error("ramp code jumped");
	chk_apb_ready: assert property (
		PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
endmodule
bind dual_buck_sequencer buck_chk buck_chk_inst (.*);

// File: sim/test_dual_buck_startup_sync_sequencer.sv
`timescale 1ns/10ps
module test_dual_buck_startup_sync_sequencer;
	logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
	logic PWRITE = 1'b0, EN = 1'b1, LOW_SUPPLY_LOCKOUT = 1'b1;
	logic THERMAL_HOT = 1'b0, slvl = 1'b0, ext_on = 1'b0, err;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
	logic [1:0] ILIM = 2'h0, PWM_OFF, OUT_GOOD, COMP_DISCHARGE;
	logic [1:0] HIGH_SIDE_GATE, LOW_SIDE_GATE;
	logic [5:0] REF_CODE;
	logic [2:0] sdiv = 3'h0;
	logic PREADY, PSLVERR, TIMING_OUTPUT, RESET_OUT_O, RESET_OUT_OE;
	wire SYNC, reset_pin;
	int n_mismatch = 0, samples_checked = 0, k, c[3];

	dual_buck_sequencer #(.OSC_PERIOD(16'h0008), .LOSS_LIMIT(8'h02))
		dual_buck_sequencer_inst (.*);
	buck_far buck_far_inst (.*);

	// external timing source with clean rises, period 6 clocks
	always @(posedge CLK) sdiv <= (sdiv == 3'h5) ? 3'h0 : sdiv + 3'h1;
	assign SYNC = ext_on ? (sdiv > 3'h2) : slvl;
	initial forever #10 CLK = ~CLK;

	// one apb transfer, read data taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rdat = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask

	// rises of hs0, hs1 and timing output over n clocks
	task cnt(input int n);
		logic [2:0] p, q;
		p = {TIMING_OUTPUT, HIGH_SIDE_GATE};
		c = '{0, 0, 0};
		repeat (n) begin
			@(posedge CLK);
			q = {TIMING_OUTPUT, HIGH_SIDE_GATE};
			for (int i = 0; i < 3; i++)
				c[i] += q[i] & ~p[i];
			p = q;
		end
	endtask

	task wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		apb(0, 8'h08, 0);
		chk("status", 32'h8, rdat);
		chk("rst pin", 0, reset_pin);
		chk("gates", 0, {HIGH_SIDE_GATE, LOW_SIDE_GATE});
		apb(1, 8'h00, 2);
		apb(0, 8'h00, 0);
		chk("osc min", 4, rdat);
		apb(1, 8'h04, 3);
		apb(0, 8'h04, 0);
		chk("loss limit", 3, rdat);
		apb(1, 8'h00, 8);
		apb(0, 8'h0C, 0);
		chk("slverr", 1, err);
		LOW_SUPPLY_LOCKOUT <= 1'b0;
		for (k = 0; reset_pin !== 1'b1 && k < 17000; k++) @(posedge CLK);
		chk("ramp up", 1, k >= 16384 && k <= 16420);
		chk("comp on", 0, COMP_DISCHARGE);
		chk("ref top", 32'h3F, REF_CODE);
		cnt(160);
		chk("timing", 10, c[2]);
		chk("hs0", 10, c[0]);
		while (HIGH_SIDE_GATE[0] !== 1'b0) @(posedge CLK);
		while (HIGH_SIDE_GATE[0] !== 1'b1) @(posedge CLK);
		for (k = 0; HIGH_SIDE_GATE[1] !== 1'b1; k++) @(posedge CLK);
		chk("phase", 8, k);
		slvl <= 1'b1;
		repeat (40) @(posedge CLK);
		cnt(160);
		chk("timing x2", 20, c[2]);
		slvl <= 1'b0;
		ext_on <= 1'b1;
		repeat (60) @(posedge CLK);
		cnt(144);
		chk("timing ext", 12, c[2]);
		chk("hs0 ext", 12, c[0]);
		apb(0, 8'h08, 0);
		chk("lock", 1, rdat[2]);
		ext_on <= 1'b0;
		repeat (60) @(posedge CLK);
		apb(0, 8'h08, 0);
		chk("unlock", 0, rdat[2]);
		cnt(160);
		chk("fallback", 10, c[0]);
		chk("rst pin", 1, reset_pin);
		ILIM <= 2'b01;
		repeat (20) @(posedge CLK);
		cnt(160);
		chk("hs0 limit", 0, c[0]);
		chk("hs1 limit", 10, c[1]);
		chk("ls0 limit", 1, LOW_SIDE_GATE[0]);
		ILIM <= 2'b00;
		EN <= 1'b0;
		for (k = 0; COMP_DISCHARGE !== 2'b11 && k < 17000; k++) @(posedge CLK);
		chk("ramp down", 1, k >= 16384 && k <= 16420);
		chk("off gates", 0, {HIGH_SIDE_GATE, LOW_SIDE_GATE});
		EN <= 1'b1;
		repeat (2000) @(posedge CLK);
		THERMAL_HOT <= 1'b1;
		repeat (4) @(posedge CLK);
		apb(0, 8'h08, 0);
		chk("hot status", 32'h10, rdat);
		THERMAL_HOT <= 1'b0;
		repeat (20) @(posedge CLK);
		apb(0, 8'h08, 0);
		chk("restart", 1, rdat[1:0]);
		wrap_up;
	end

	// hang guard
	initial begin
		repeat (50000) @(posedge CLK);
		n_mismatch++;
		wrap_up;
	end
endmodule
